// >>> design/hexdff_defs.svh
// constants for the six-bit dual-clock edge-triggered register
`ifndef HEXDFF_DEFS_SVH
`define HEXDFF_DEFS_SVH

// ==========================================================================
// widths
// ==========================================================================
`define HEXDFF_WIDTH 6

// ==========================================================================
// reset values
// ==========================================================================
// true side of a storage bit after clear
`define HEXDFF_TRUE_RST 1'b0
// complement side of a storage bit after clear
`define HEXDFF_COMP_RST 1'b1
// master stage after clear
`define HEXDFF_MASTER_RST 1'b0
// last seen clock level after clear; high so a clock already high is no edge
`define HEXDFF_PREV_CLK_RST 1'b1

`endif

// >>> design/hexdff_pkg.sv
// types shared by the six-bit dual-clock register
package hexdff_pkg;

    // ======================================================================
    // clock pair
    // ======================================================================
    typedef struct packed {
        logic first;
        logic second;
    } hexdff_clk_pair_s;

    // ======================================================================
    // state of one storage bit
    // ======================================================================
    typedef struct packed {
        logic master;
        logic slave_true;
        logic slave_comp;
    } hexdff_cell_s;

    // ======================================================================
    // state of the shared clock edge logic
    // ======================================================================
    typedef struct packed {
        hexdff_clk_pair_s prev;
    } hexdff_top_s;

endpackage : hexdff_pkg

// >>> design/hexdff_cell.sv
// one master/slave storage bit with true and complement outputs
`include "hexdff_defs.svh"

module hexdff_cell
    import hexdff_pkg::*;
(
    input wire logic clk,
    input wire logic clear_any,
    input wire logic follow,
    input wire logic load,
    input wire logic data_in,
    output logic master_out,
    output logic true_out,
    output logic comp_out
);

    // ======================================================================
    // state
    // ======================================================================
    hexdff_cell_s st_q;
    hexdff_cell_s st_d;

    // master follows data while open, slave takes master on a load
    always_comb begin
        st_d = st_q;
        if (follow) begin
            st_d.master = data_in;
        end
        if (load) begin
            st_d.slave_true = st_q.master;
            st_d.slave_comp = ~st_q.master;
        end
    end

    // clear forces the constant state at once, with no clock needed
    always_ff @(posedge clk or posedge clear_any) begin
        if (clear_any) begin
            st_q.master <= `HEXDFF_MASTER_RST;
            st_q.slave_true <= `HEXDFF_TRUE_RST;
            st_q.slave_comp <= `HEXDFF_COMP_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign master_out = st_q.master;
    assign true_out = st_q.slave_true;
    assign comp_out = st_q.slave_comp;

endmodule : hexdff_cell

// >>> design/hexdff_top.sv
// six-bit edge-triggered register with a clock pair and asynchronous clear
//
// Overview of operation
// - six storage bits share one clock pair and one clear input
// - each bit drives a true output and its exact inverse
// - master stage follows data only while both clocks are low
// - a loading clock rise passes the master value to slave and outputs
// - one clock rising while the other is low loads data from before
// - outputs hold on a rise with other clock high, or clocks idle low
// - clear high forces every true output low over data and clocks
// - clear acts at once, without waiting for any clock edge
`include "hexdff_defs.svh"

module hexdff_top
    import hexdff_pkg::*;
#(
    parameter int WIDTH = `HEXDFF_WIDTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] bit_inputs,
    input wire logic clock_in_first,
    input wire logic clock_in_second,
    input wire logic async_clear_in,
    output logic [WIDTH-1:0] bit_outputs_true,
    output logic [WIDTH-1:0] bit_outputs_comp
);

    // ======================================================================
    // clock pair edge detection
    // ======================================================================
    hexdff_top_s st_q;
    hexdff_top_s st_d;
    hexdff_clk_pair_s clk_now;
    logic clear_any;
    logic rise_first;
    logic rise_second;
    logic follow;
    logic load;
    logic [WIDTH-1:0] master_vec;

    // the clear pin and system reset both clear the whole register
    assign clear_any = sys_rst | async_clear_in;

    // group the clock pair
    assign clk_now.first = clock_in_first;
    assign clk_now.second = clock_in_second;

    // rising edges as seen against the previous sampled level
    assign rise_first = clk_now.first & ~st_q.prev.first;
    assign rise_second = clk_now.second & ~st_q.prev.second;

    // master is open only while both clocks are low
    assign follow = ~clk_now.first & ~clk_now.second;

    // load when one rises with the other low, or when both rise together
    always_comb begin
        load = 1'b0;
        if (rise_first && !clk_now.second) begin
            load = 1'b1;
        end
        if (rise_second && !clk_now.first) begin
            load = 1'b1;
        end
        if (rise_first && rise_second) begin
            load = 1'b1;
        end
        // a rise against a clock already high leaves load low
    end

    // next state of the edge detector
    always_comb begin
        st_d = st_q;
        st_d.prev = clk_now;
    end

    // previous clock levels; reset high so a held-high clock is no edge
    always_ff @(posedge clk or posedge clear_any) begin
        if (clear_any) begin
            st_q.prev.first <= `HEXDFF_PREV_CLK_RST;
            st_q.prev.second <= `HEXDFF_PREV_CLK_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ======================================================================
    // storage bits
    // ======================================================================
    // six identical bits on the shared clock and clear controls
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            hexdff_cell u_cell (
                .clk(clk),
                .clear_any(clear_any),
                .follow(follow),
                .load(load),
                .data_in(bit_inputs[i]),
                .master_out(master_vec[i]),
                .true_out(bit_outputs_true[i]),
                .comp_out(bit_outputs_comp[i])
            );
        end
    endgenerate

    // ======================================================================
    // assertions
    // ======================================================================
    default clocking cb_main @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // complement always mirrors the true output
    property p_comp_inverse;
        bit_outputs_comp == ~bit_outputs_true;
    endproperty
    a_comp_inverse: assert property (p_comp_inverse)
        else $error("complement output is not the inverse of true output");

    // master takes the data seen while both clocks are low
    property p_master_follow;
        (follow && !async_clear_in) ##1 !async_clear_in
            |-> master_vec == $past(bit_inputs);
    endproperty
    a_master_follow: assert property (p_master_follow)
        else $error("master did not follow data with both clocks low");

    // master frozen while either clock is high
    property p_master_frozen;
        (!follow && !async_clear_in) ##1 !async_clear_in |-> $stable(master_vec);
    endproperty
    a_master_frozen: assert property (p_master_frozen)
        else $error("master changed while a clock was high");

    // first clock rising with second low loads the prior data
    property p_load_first;
        (rise_first && !clock_in_second && !async_clear_in) ##1 !async_clear_in
            |-> bit_outputs_true == $past(master_vec);
    endproperty
    a_load_first: assert property (p_load_first)
        else $error("rise of first clock did not load the outputs");

    // second clock rising with first low loads the prior data
    property p_load_second;
        (rise_second && !clock_in_first && !async_clear_in) ##1 !async_clear_in
            |-> bit_outputs_true == $past(master_vec);
    endproperty
    a_load_second: assert property (p_load_second)
        else $error("rise of second clock did not load the outputs");

    // both clocks rising together still load
    property p_load_both;
        (rise_first && rise_second && !async_clear_in) ##1 !async_clear_in
            |-> bit_outputs_true == $past(master_vec);
    endproperty
    a_load_both: assert property (p_load_both)
        else $error("joint rise of both clocks did not load the outputs");

    // a rise against a clock already high holds the outputs
    property p_hold_other_high;
        (((rise_first && st_q.prev.second && clock_in_second)
          || (rise_second && st_q.prev.first && clock_in_first))
         && !async_clear_in) ##1 !async_clear_in |-> $stable(bit_outputs_true);
    endproperty
    a_hold_other_high: assert property (p_hold_other_high)
        else $error("outputs changed on a rise against a high clock");

    // idle low clocks hold the outputs for two cycles
    property p_hold_idle;
        (follow && !st_q.prev.first && !st_q.prev.second && !async_clear_in)
            ##1 (!async_clear_in && follow) ##1 !async_clear_in
            |-> $stable(bit_outputs_true) && bit_outputs_true == $past(bit_outputs_true, 2);
    endproperty
    a_hold_idle: assert property (p_hold_idle)
        else $error("outputs changed while both clocks idled low");

    // all six bits change only together on a load
    property p_common_load;
        (!load && !async_clear_in) ##1 !async_clear_in |-> $stable(bit_outputs_true);
    endproperty
    a_common_load: assert property (p_common_load)
        else $error("outputs changed without a shared clock load");

    // clear holds every true output low whatever the clocks do
    property p_clear_low;
        async_clear_in |-> bit_outputs_true == '0 && master_vec == '0;
    endproperty
    a_clear_low: assert property (p_clear_low)
        else $error("true outputs not low while clear is high");

    // clear shows already at the first edge it is seen, no clock rise needed
    property p_clear_now;
        ($rose(async_clear_in) && !rise_first && !rise_second)
            |-> bit_outputs_true == '0 ##1 (!async_clear_in || bit_outputs_true == '0);
    endproperty
    a_clear_now: assert property (p_clear_now)
        else $error("clear did not act without a clock edge");

    // complement side shows all ones while clear is high
    property p_comp_clear;
        async_clear_in |-> bit_outputs_comp == '1;
    endproperty
    a_comp_clear: assert property (p_comp_clear)
        else $error("complement outputs not high while clear is high");

    // a clock left high across clear release is not taken as a rise
    property p_release_no_load;
        async_clear_in ##1 !async_clear_in |-> !load;
    endproperty
    a_release_no_load: assert property (p_release_no_load)
        else $error("load taken at the first edge after clear release");

    // both clocks resting low never load
    property p_idle_no_load;
        !clock_in_first && !clock_in_second |-> !load;
    endproperty
    a_idle_no_load: assert property (p_idle_no_load)
        else $error("load taken while both clocks rest low");

    // main scenarios
    c_load_first: cover property (rise_first && !clock_in_second && !async_clear_in);
    c_load_second: cover property (rise_second && !clock_in_first && !async_clear_in);
    c_load_both: cover property (rise_first && rise_second && !async_clear_in);
    c_rise_blocked: cover property (rise_first && clock_in_second && st_q.prev.second);
    c_clear_over_load: cover property (async_clear_in && (clock_in_first || clock_in_second));

endmodule : hexdff_top

// >>> tb/hexdff_partner.sv
// partner model: surrounding logic that drives data, clock pair and clear
module hexdff_partner
    import hexdff_pkg::*;
(
    input wire logic clk,
    output logic [5:0] data_o,
    output hexdff_clk_pair_s clks_o,
    output logic clear_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ======================================================================
    // pin drivers
    // ======================================================================
    // idle pins from time zero
    initial begin
        data_o = 6'h00;
        clks_o = 2'b00;
        clear_o = 1'b0;
    end

    // one cycle of pin values, applied at the falling edge
    task automatic drive(input logic [5:0] d, input logic [1:0] c, input logic clr);
        @(negedge clk);
        data_o <= d;
        clks_o <= c;
        clear_o <= clr;
    endtask : drive

    // capture with both clocks low, then raise the chosen clocks; data
    // is no longer held once a clock is high, so it shows the inverse
    task automatic load(input logic [5:0] d, input logic [1:0] sel);
        drive(d, 2'b00, 1'b0);
        drive(~d, sel, 1'b0);
    endtask : load
endmodule : hexdff_partner

// >>> tb/testbench.sv
// self-checking bench for the six-bit dual-clock register
module testbench
    import hexdff_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ======================================================================
    // signals
    // ======================================================================
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] data_w;
    hexdff_clk_pair_s clks_w;
    logic clear_w;
    logic [5:0] q_true;
    logic [5:0] q_comp;
    logic [5:0] exp_q[$];
    logic [5:0] e_m;
    logic [5:0] d;
    logic chk = 1'b0;
    int fails = 0;
    int total_checks = 0;

    // 25 MHz clock
    always #20 clk = ~clk;

    hexdff_top #(.WIDTH(6)) hexdff_top_i (
        .clk(clk),
        .sys_rst(sys_rst),
        .bit_inputs(data_w),
        .clock_in_first(clks_w.first),
        .clock_in_second(clks_w.second),
        .async_clear_in(clear_w),
        .bit_outputs_true(q_true),
        .bit_outputs_comp(q_comp)
    );

    hexdff_partner hexdff_partner_i (
        .clk(clk),
        .data_o(data_w),
        .clks_o(clks_w),
        .clear_o(clear_w)
    );

    // ======================================================================
    // checking
    // ======================================================================
    // compare and count
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // note the value expected after the coming clock edge
    task automatic post(input logic [5:0] v);
        exp_q.push_back(v);
        chk = 1'b1;
    endtask : post

    // watcher: compares outputs with the oldest note once the edge settled
    always @(posedge clk) begin
        #1;
        if (chk) begin
            chk = 1'b0;
            e_m = exp_q.pop_front();
            check("outputs", {q_true, q_comp}, {e_m, ~e_m});
        end
    end

    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    // hang guard
    initial begin
        repeat (2000) @(posedge clk);
        fails++;
        $display("timeout");
        end_of_test();
    end

    // ======================================================================
    // scenarios
    // ======================================================================
    initial begin
        void'($urandom(32'h6671));
        repeat (20) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        #1 check("after reset", {q_true, q_comp}, 12'h03F);
        $display("test reset done");
        // random loads through first, second and both clocks
        for (int i = 0; i < 12; i++) begin
            d = 6'($urandom);
            hexdff_partner_i.load(d, 2'(i % 3 + 1));
            post(d);
        end
        $display("test loads done");
        // rise with other clock high, idle low, frozen master
        d = 6'($urandom);
        hexdff_partner_i.load(d, 2'b10);
        post(d);
        hexdff_partner_i.drive(~d, 2'b11, 1'b0);
        post(d);
        hexdff_partner_i.drive(6'h3F ^ d, 2'b01, 1'b0);
        post(d);
        hexdff_partner_i.drive(d ^ 6'h15, 2'b00, 1'b0);
        post(d);
        hexdff_partner_i.drive(d ^ 6'h2A, 2'b00, 1'b0);
        post(d);
        hexdff_partner_i.drive(d, 2'b10, 1'b0);
        post(d ^ 6'h2A);
        $display("test hold done");
        // clear over data and clocks
        hexdff_partner_i.load(6'h3F, 2'b01);
        post(6'h3F);
        hexdff_partner_i.drive(6'h00, 2'b11, 1'b0);
        post(6'h3F);
        hexdff_partner_i.drive(6'h3F, 2'b00, 1'b1);
        #1 check("clear now", {q_true, q_comp}, 12'h03F);
        post(6'h00);
        hexdff_partner_i.drive(6'h3F, 2'b10, 1'b1);
        post(6'h00);
        hexdff_partner_i.drive(6'h15, 2'b10, 1'b0);
        post(6'h00);
        hexdff_partner_i.load(6'h2A, 2'b01);
        post(6'h2A);
        // system reset in mid-run
        @(negedge clk);
        sys_rst = 1'b1;
        #1 check("reset now", {q_true, q_comp}, 12'h03F);
        @(negedge clk);
        sys_rst = 1'b0;
        hexdff_partner_i.load(6'h00, 2'b10);
        post(6'h00);
        hexdff_partner_i.load(6'h33, 2'b11);
        post(6'h33);
        $display("test clear done");
        repeat (2) @(posedge clk);
        end_of_test();
    end
endmodule : testbench
